/* src/mbrtc_pkg.sv */
// Shared constants and types for the multiplexed-bus RTC host port
package mbrtc_pkg;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam int       ADDR_W       = 7;        // 128 locations
	localparam int       DATA_W       = 8;        // Byte wide bus
	localparam int       LOCATIONS    = 128;      // Whole map
	localparam logic [6:0] LOC_SECONDS = 7'h00;   // Seconds byte
	localparam logic [6:0] LOC_CTRL_A  = 7'h0A;   // First control register
	localparam logic [6:0] LOC_CTRL_B  = 7'h0B;   // Second control register
	localparam logic [6:0] LOC_CTRL_C  = 7'h0C;   // Flag register
	localparam logic [6:0] LOC_CTRL_D  = 7'h0D;   // Validity register

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_RO_TOP    = 7;             // Read-only top bit
	localparam int BIT_PIE       = 6;             // Periodic enable in B
	localparam int BIT_AIE       = 5;             // Alarm enable in B
	localparam int BIT_UIE       = 4;             // Update enable in B
	localparam int BIT_SQUARE_WAVE_ENABLE      = 3;             // Square wave enable in B
	localparam int BIT_COMBINED_INT_FLAG      = 7;             // Combined flag in C
	localparam int BIT_PF        = 6;             // Periodic flag in C
	localparam int BIT_AF        = 5;             // Alarm flag in C
	localparam int BIT_UF        = 4;             // Update flag in C
	localparam int RATE_W        = 4;             // Rate select width

	// ----------------------------------------------------------------
	// Reset values and constants
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_A_RESET  = 8'h00;   // A after power-on
	localparam logic [7:0] CTRL_B_RESET  = 8'h00;   // B after power-on
	localparam logic [7:0] CTRL_D_VALUE  = 8'h80;   // Contents valid
	localparam logic [7:0] B_ENABLE_MASK = 8'h78;   // Enables cleared by pin

	// ----------------------------------------------------------------
	// Timebase
	// ----------------------------------------------------------------
	localparam int CLK_HZ       = 100_000_000;      // System clock
	localparam int XTAL_HZ      = 32_768;           // Crystal rate
	localparam int TICK_CYCLES  = CLK_HZ / XTAL_HZ;  // Clocks per crystal tick
	localparam int CHAIN_W      = 15;               // Divider stages
	localparam int TAP_LOW_OFS  = 2;                // Codes 3..15 to tap
	localparam int TAP_ALIAS    = 5;                // Codes 1..2 to tap

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ad;            // Shared address/data lines in
		logic       addr_strobe;   // Address latch strobe
		logic       data_strobe;   // Data strobe or read enable
		logic       dir;           // Direction or write enable
		logic       cs_n;          // Chip select, low active
	} mbrtc_pins_t;

	typedef struct packed {
		logic periodic;            // Periodic flag
		logic alarm;               // Alarm flag
		logic update;              // Update-done flag
	} mbrtc_flags_t;

	typedef enum logic [2:0] {
		BUS_IDLE  = 3'b001,        // No cycle in progress
		BUS_READ  = 3'b010,        // Driving read data
		BUS_WRITE = 3'b100         // Collecting write data
	} mbrtc_bus_state_t;

endpackage

/* src/mbrtc_rate_gen.sv */
// Crystal divider chain with selectable tap for periodic and square wave
`timescale 1ns/1ps
module mbrtc_rate_gen
	import mbrtc_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES       // Clocks per crystal tick
)
(
	input  wire logic              i_clk,        // System clock
	input  wire logic              i_rst,        // Async reset, high
	input  wire logic [RATE_W-1:0] i_rate,       // Rate select code
	output logic                   o_tap,        // Selected tap level
	output logic                   o_periodic    // One pulse per period
);

	// Refuse a tick divider the 12-bit prescaler cannot count
	if (TICK_DIV < 2 || TICK_DIV > 4096)
	begin : g_bad_div
		$error("mbrtc_rate_gen: TICK_DIV out of range");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [11:0]        pre;          // Prescaler to crystal tick
	logic [CHAIN_W-1:0] chain;        // Fifteen divider stages
	logic [11:0]        next_pre;     // Next prescaler
	logic [CHAIN_W-1:0] next_chain;   // Next chain
	logic               next_tap;     // Next tap output
	logic               next_periodic;// Next periodic pulse
	logic [3:0]         tap_idx;      // Chosen stage

	// Tap choice, rate step and periodic edge
	always_comb
	begin
		tap_idx = 4'h0;
		if (i_rate == 4'h1 || i_rate == 4'h2)
			tap_idx = i_rate + 4'(TAP_ALIAS);
		else if (i_rate != 4'h0)
			tap_idx = i_rate - 4'(TAP_LOW_OFS);
		next_pre      = pre + 12'h001;
		next_chain    = chain;
		next_periodic = 1'b0;
		if (pre == 12'(TICK_DIV - 1))
		begin
			next_pre   = 12'h000;
			next_chain = chain + 15'h0001;
			// Period ends when the chosen stage falls
			next_periodic = (i_rate != 4'h0) && chain[tap_idx] && !next_chain[tap_idx];
		end
		next_tap = (i_rate != 4'h0) && chain[tap_idx];
	end

	// Register divider state
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			pre        <= 12'h000;
			chain      <= 15'h0000;
			o_tap      <= 1'b0;
			o_periodic <= 1'b0;
		end
		else
		begin
			pre        <= next_pre;
			chain      <= next_chain;
			o_tap      <= next_tap;
			o_periodic <= next_periodic;
		end
	end

endmodule

/* src/mbrtc_host_port.sv */
// Host port of the RTC: muxed bus, control registers, RAM, interrupt, SRAM enable
`timescale 1ns/1ps
module mbrtc_host_port
	import mbrtc_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES               // Clocks per crystal tick
)
(
	input  wire logic        i_clk,                    // System clock
	input  wire logic        i_rst,                    // Async reset, high
	input  wire mbrtc_pins_t i_bus,                    // Bus pins in
	input  wire logic        i_bus_style_select,       // High: strobe style
	input  wire logic        i_reset_n,                // Device reset pin
	input  wire logic        i_supply_ok,              // Supply above limit
	input  wire logic        i_sram_enable_in_n,       // SRAM enable in
	input  wire logic        i_update_busy,            // Update in progress
	input  wire logic        i_update_done_evt,        // Update ended pulse
	input  wire logic        i_alarm_evt,              // Alarm match pulse
	output logic [7:0]       o_ad,                     // Bus data out
	output logic             o_ad_oe_n,                // Low while driving bus
	output logic             o_irq_n,                  // Interrupt level out
	output logic             o_irq_oe_n,               // Low while pulling low
	output logic             o_sram_enable_out_n,      // SRAM enable out
	output logic             o_square_wave_out,        // Square wave
	output logic [7:0]       o_ctrl_b                  // Second control reg
);

	// Refuse a tick divider the divider chain cannot serve
	if (TICK_DIV < 2 || TICK_DIV > 4096)
	begin : g_bad_div
		$error("mbrtc_host_port: TICK_DIV out of range");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]       mem [0:LOCATIONS-1];   // Time bytes and RAM
	mbrtc_bus_state_t state;                 // Bus cycle state
	mbrtc_bus_state_t next_state;            // Next bus state
	logic [6:0]       addr;                  // Latched location
	logic [6:0]       next_addr;             // Next location
	logic [7:0]       wdata;                 // Held write data
	logic [7:0]       next_wdata;            // Next write data
	logic             as_q;                  // Strobe last cycle
	logic [6:0]       ctrl_a;                // First control reg
	logic [6:0]       next_ctrl_a;           // Next first control
	logic [7:0]       next_ctrl_b;           // Next second control
	mbrtc_flags_t     flags;                 // Interrupt flags
	mbrtc_flags_t     next_flags;            // Next flags
	mbrtc_flags_t     snap;                  // Flags seen by read
	mbrtc_flags_t     next_snap;             // Next snapshot
	logic             mem_we;                // Commit to storage
	logic [7:0]       mem_wd;                // Byte to store
	logic [7:0]       rd_byte;               // Read mux result
	logic [7:0]       next_ad;               // Next bus data
	logic             irq_cond;              // Enabled flag present
	logic             rd_active;             // Read strobe active
	logic             wr_active;             // Write strobe active
	logic             pin_reset;             // Reset pin effective
	logic             cs_ok;                 // Chip select effective
	logic             tap;                   // Divider tap
	logic             periodic_evt;          // Periodic pulse

	// ----------------------------------------------------------------
	// Divider chain
	// ----------------------------------------------------------------
	mbrtc_rate_gen #(
		.TICK_DIV (TICK_DIV)
	) u_rate (
		.i_clk      (i_clk),
		.i_rst      (i_rst),
		.i_rate     (ctrl_a[RATE_W-1:0]),
		.o_tap      (tap),
		.o_periodic (periodic_evt)
	);

	// ----------------------------------------------------------------
	// Cycle decode
	// ----------------------------------------------------------------

	// Strobe meaning per timing style
	always_comb
	begin
		pin_reset = !i_reset_n && i_supply_ok;
		// Access needs chip select, valid supply and reset pin high
		cs_ok = !i_bus.cs_n && i_supply_ok && i_reset_n;
		if (i_bus_style_select)
		begin
			rd_active = i_bus.data_strobe && i_bus.dir;
			wr_active = i_bus.data_strobe && !i_bus.dir;
		end
		else
		begin
			rd_active = !i_bus.data_strobe;
			wr_active = !i_bus.dir;
		end
	end

	// ----------------------------------------------------------------
	// Bus state machine
	// ----------------------------------------------------------------

	// Next bus state, address, write data and storage commit
	always_comb
	begin
		next_state = state;
		next_addr  = addr;
		next_wdata = wdata;
		mem_we     = 1'b0;
		mem_wd     = wdata;
		next_ctrl_a = ctrl_a;
		next_ctrl_b = o_ctrl_b;
		// Address taken on strobe fall, whatever chip select does
		if (as_q && !i_bus.addr_strobe)
			next_addr = i_bus.ad[6:0];
		unique case (state)
			BUS_IDLE:
			begin
				if (cs_ok && rd_active)
					next_state = BUS_READ;
				else if (cs_ok && wr_active)
				begin
					next_state = BUS_WRITE;
					next_wdata = i_bus.ad;
				end
			end
			BUS_READ:
			begin
				// Read ends when its strobe drops or access is lost
				if (!rd_active || !cs_ok)
					next_state = BUS_IDLE;
			end
			BUS_WRITE:
			begin
				if (!cs_ok)
					next_state = BUS_IDLE;
				else if (wr_active)
					next_wdata = i_bus.ad;
				else
				begin
					// Trailing edge of the write strobe stores the byte
					next_state = BUS_IDLE;
					unique case (addr)
						LOC_CTRL_A: next_ctrl_a = wdata[6:0];
						LOC_CTRL_B: next_ctrl_b = wdata;
						LOC_CTRL_C, LOC_CTRL_D: ;
						default:
						begin
							mem_we = 1'b1;
							if (addr == LOC_SECONDS)
								mem_wd = {mem[LOC_SECONDS][BIT_RO_TOP], wdata[6:0]};
						end
					endcase
				end
			end
			default: next_state = BUS_IDLE;
		endcase
		// Reset pin clears enables only, not other B bits
		if (pin_reset)
			next_ctrl_b = o_ctrl_b & ~B_ENABLE_MASK;
	end

	// Register bus state
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state    <= BUS_IDLE;
			addr     <= 7'h00;
			wdata    <= 8'h00;
			as_q     <= 1'b0;
			ctrl_a   <= CTRL_A_RESET[6:0];
			o_ctrl_b <= CTRL_B_RESET;
		end
		else
		begin
			state    <= next_state;
			addr     <= next_addr;
			wdata    <= next_wdata;
			as_q     <= i_bus.addr_strobe;
			ctrl_a   <= next_ctrl_a;
			o_ctrl_b <= next_ctrl_b;
		end
	end

	// Storage keeps contents across any reset
	always_ff @(posedge i_clk)
	begin
		if (mem_we)
			mem[addr] <= mem_wd;
	end

	// ----------------------------------------------------------------
	// Interrupt flags
	// ----------------------------------------------------------------

	// Flag set, read-clear and reset pin clear
	always_comb
	begin
		next_snap  = snap;
		next_flags = flags;
		// Freeze flags for the whole read of the flag register
		if (state == BUS_IDLE && next_state == BUS_READ)
			next_snap = flags;
		// Clear what the read returned once the read completes
		if (state == BUS_READ && addr == LOC_CTRL_C && cs_ok && !rd_active)
			next_flags = flags & ~snap;
		// A new event in the clearing cycle is kept
		next_flags.periodic = next_flags.periodic | periodic_evt;
		next_flags.alarm    = next_flags.alarm | i_alarm_evt;
		next_flags.update   = next_flags.update | i_update_done_evt;
		if (pin_reset)
			next_flags = '0;
		// Any flag with its enable asserts the pin next cycle
		irq_cond = (next_flags.periodic && next_ctrl_b[BIT_PIE])
			|| (next_flags.alarm && next_ctrl_b[BIT_AIE])
			|| (next_flags.update && next_ctrl_b[BIT_UIE]);
	end

	// Register flags
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			flags <= '0;
			snap  <= '0;
		end
		else
		begin
			flags <= next_flags;
			snap  <= next_snap;
		end
	end

	// ----------------------------------------------------------------
	// Read data and pin outputs
	// ----------------------------------------------------------------

	// Read mux over the map
	always_comb
	begin
		unique case (addr)
			LOC_CTRL_A: rd_byte = {i_update_busy, ctrl_a};
			LOC_CTRL_B: rd_byte = o_ctrl_b;
			LOC_CTRL_C: rd_byte = {(o_irq_oe_n == 1'b0), snap.periodic,
				snap.alarm, snap.update, 4'h0};
			LOC_CTRL_D: rd_byte = CTRL_D_VALUE;
			default:    rd_byte = mem[addr];
		endcase
		next_ad = (next_state == BUS_READ) ? rd_byte : o_ad;
	end

	// Register all pin outputs
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_ad                <= 8'h00;
			o_ad_oe_n           <= 1'b1;
			o_irq_n             <= 1'b0;
			o_irq_oe_n          <= 1'b1;
			o_sram_enable_out_n <= 1'b1;
			o_square_wave_out   <= 1'b0;
		end
		else
		begin
			o_ad                <= next_ad;
			o_ad_oe_n           <= (next_state != BUS_READ);
			o_irq_n             <= 1'b0;
			o_irq_oe_n          <= !irq_cond;
			o_sram_enable_out_n <= (i_supply_ok && i_reset_n)
				? i_sram_enable_in_n : 1'b1;
			o_square_wave_out   <= tap && o_ctrl_b[BIT_SQUARE_WAVE_ENABLE] && i_supply_ok;
		end
	end

endmodule

/* tb/mbrtc_port_checker.sv */
// Pin-level assertions for the RTC host port
`timescale 1ns/1ps
module mbrtc_port_checker
	import mbrtc_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES  // Clocks per crystal tick
)
(
	input wire logic        i_clk,               // Clock
	input wire logic        i_rst,               // Reset
	input wire mbrtc_pins_t i_bus,               // Bus pins
	input wire logic        i_bus_style_select,  // Style
	input wire logic        i_reset_n,           // Device reset pin
	input wire logic        i_supply_ok,         // Supply valid
	input wire logic        i_sram_enable_in_n,  // SRAM enable in
	input wire logic [7:0]  o_ad,                // Read data
	input wire logic        o_ad_oe_n,           // Bus drive, low
	input wire logic        o_irq_oe_n,          // Interrupt pull
	input wire logic        o_sram_enable_out_n, // SRAM enable out
	input wire logic        o_square_wave_out,   // Square wave
	input wire logic [7:0]  o_ctrl_b             // Second control reg
);
	// ----------------------------------------------------------------
	// Helpers and sequences
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic cs_ok;  // Access allowed
	logic rd_on;  // Read strobe active
	assign cs_ok = !i_bus.cs_n && i_supply_ok && i_reset_n;
	assign rd_on = i_bus_style_select ? (i_bus.data_strobe && i_bus.dir) : !i_bus.data_strobe;
	sequence s_rd_go;
		o_ad_oe_n && cs_ok && rd_on && !$past(rd_on);
	endsequence
	sequence s_rd_end;
		!o_ad_oe_n && !rd_on;
	endsequence
	sequence s_pin_rst;
		!i_reset_n && i_supply_ok;
	endsequence
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_read_drive: assert property (s_rd_go |=> !o_ad_oe_n)
		else $error("read start did not drive the bus");
	a_read_release: assert property (s_rd_end |=> o_ad_oe_n)
		else $error("bus not released after read");
	a_blocked_idle: assert property (o_ad_oe_n && !cs_ok |=> o_ad_oe_n)
		else $error("bus driven without access");
	a_pin_clear_en: assert property (s_pin_rst |=> o_ctrl_b[6:3] == 4'h0)
		else $error("enables not cleared by reset pin");
	a_pin_float_irq: assert property (s_pin_rst |=> o_irq_oe_n)
		else $error("interrupt held during reset pin");
	a_pin_sram_high: assert property (!i_reset_n |=> o_sram_enable_out_n)
		else $error("SRAM enable low during reset pin");
	a_sram_follow: assert property (i_supply_ok && i_reset_n |=>
		o_sram_enable_out_n == $past(i_sram_enable_in_n))
		else $error("SRAM enable does not follow input");
	a_supply_sram: assert property (!i_supply_ok |=> o_sram_enable_out_n)
		else $error("SRAM enable low on low supply");
	a_irq_masked: assert property (o_ctrl_b[6:4] == 3'h0 |-> o_irq_oe_n)
		else $error("interrupt without enable");
	a_sqw_off: assert property (!o_ctrl_b[3] |=> !o_square_wave_out)
		else $error("square wave while disabled");
endmodule

bind mbrtc_host_port mbrtc_port_checker #(.TICK_DIV(TICK_DIV)) chk_u (.i_clk(i_clk),
	.i_rst(i_rst), .i_bus(i_bus), .i_bus_style_select(i_bus_style_select),
	.i_reset_n(i_reset_n), .i_supply_ok(i_supply_ok), .i_sram_enable_in_n(i_sram_enable_in_n),
	.o_ad(o_ad), .o_ad_oe_n(o_ad_oe_n), .o_irq_oe_n(o_irq_oe_n),
	.o_sram_enable_out_n(o_sram_enable_out_n), .o_square_wave_out(o_square_wave_out),
	.o_ctrl_b(o_ctrl_b));

/* tb/mbrtc_host_bfm.sv */
// Bus master model driving the multiplexed address/data pins
`timescale 1ns/1ps
module mbrtc_host_bfm
	import mbrtc_pkg::*;
(
	input  wire logic       i_clk,     // Clock
	input  wire logic       i_style,   // High: strobe style
	input  wire logic [7:0] i_ad,      // Device read data
	input  wire logic       i_ad_oe_n, // Device drives, low
	output mbrtc_pins_t     o_bus      // Bus pins to device
);
	// ----------------------------------------------------------------
	// Bus cycles, changed only at falling edges
	// ----------------------------------------------------------------
	initial o_bus = '{8'h00, 1'b0, 1'b0, 1'b1, 1'b1};  // Idle, deselected

	// Idle strobe levels for the current style
	task automatic park;
		@(negedge i_clk);
		o_bus.data_strobe = ~i_style;
		o_bus.dir = 1'b1;
	endtask

	// One address phase then one data phase
	task automatic access(input logic [7:0] a, input logic wr, input logic [7:0] d,
		input logic cs, output logic [7:0] q, output logic drv);
		@(negedge i_clk);
		o_bus.ad = a;               // Address settles before the strobe falls
		o_bus.addr_strobe = 1'b1;
		o_bus.cs_n = ~cs;           // Select held through the data phase
		@(negedge i_clk);
		o_bus.addr_strobe = 1'b0;
		@(negedge i_clk);
		o_bus.ad = wr ? d : ~a;     // Write data held; read leaves lines changed
		o_bus.data_strobe = i_style | wr;
		o_bus.dir = ~wr;
		repeat (3) @(negedge i_clk);
		q = i_ad;
		drv = ~i_ad_oe_n;
		o_bus.data_strobe = ~i_style;
		o_bus.dir = 1'b1;
		repeat (2) @(negedge i_clk);
		o_bus.cs_n = 1'b1;
		o_bus.ad = ~o_bus.ad;       // Lines released after hold time
		@(negedge i_clk);
	endtask
endmodule

/* tb/test_muxed_bus_rtc_host_port.sv */
// Self-checking bench for the RTC host port
`timescale 1ns/1ps
module test_muxed_bus_rtc_host_port;
	import mbrtc_pkg::*;
	localparam int TDIV = 2;  // Short crystal tick
	logic        clk, rst, style, reset_n, supply, sram_in, busy, upd_evt, alm_evt;  // Inputs
	mbrtc_pins_t bus;                                      // Bus pins
	logic [7:0]  ad, ctrl_b, q;                            // Data
	logic        ad_oe_n, irq_n, irq_oe_n, sram_out, square_wave_out, drv;  // Outputs
	logic [15:0] p;                                        // Measured period
	int          errors, samples_checked, cyc;             // Counters

	// ----------------------------------------------------------------
	// Design, bus master and clock
	// ----------------------------------------------------------------
	mbrtc_host_port #(.TICK_DIV(TDIV)) dut_u (.i_clk(clk), .i_rst(rst), .i_bus(bus),
		.i_bus_style_select(style), .i_reset_n(reset_n), .i_supply_ok(supply),
		.i_sram_enable_in_n(sram_in), .i_update_busy(busy), .i_update_done_evt(upd_evt),
		.i_alarm_evt(alm_evt), .o_ad(ad), .o_ad_oe_n(ad_oe_n), .o_irq_n(irq_n),
		.o_irq_oe_n(irq_oe_n), .o_sram_enable_out_n(sram_out), .o_square_wave_out(square_wave_out),
		.o_ctrl_b(ctrl_b));
	mbrtc_host_bfm host_u (.i_clk(clk), .i_style(style), .i_ad(ad), .i_ad_oe_n(ad_oe_n),
		.o_bus(bus));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chkv({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_u.access(a, 1'b1, d, 1'b1, q, drv);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		host_u.access(a, 1'b0, 8'h00, 1'b1, q, drv);
		chk1(drv, 1'b1);
		chkv({8'h00, q}, {8'h00, e});
	endtask
	task automatic pulse_alarm;
		@(negedge clk) alm_evt = 1'b1;
		@(negedge clk) alm_evt = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	// Cycles between two rising edges of the square wave, zero if none
	task automatic sqw_period(output logic [15:0] per);
		logic prev;
		int   n, t0, k;
		prev = square_wave_out;
		k = 0;
		t0 = 0;
		per = 16'h0000;
		for (n = 0; n < 2000 && k < 2; n++)
		begin
			@(negedge clk);
			if (square_wave_out && !prev)
			begin
				k++;
				per = 16'(n - t0);
				t0 = n;
			end
			prev = square_wave_out;
		end
		if (k < 2)
			per = 16'h0000;
	endtask
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Hang limit
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			errors++;
			conclude;
		end
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		{rst, style, reset_n, supply, sram_in} = 5'b11111;
		{busy, upd_evt, alm_evt} = 3'b000;
		errors = 0;
		samples_checked = 0;
		cyc = 0;
		repeat (10) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		wr(8'h20, 8'hA5); rd(8'h20, 8'hA5);
		wr(8'hA1, 8'h5A); rd(8'h21, 8'h5A);
		wr(8'h7F, 8'hC3); rd(8'h7F, 8'hC3);
		wr(8'h0D, 8'h00); rd(8'h0D, 8'h80);
		wr(8'h0A, 8'hFF); rd(8'h0A, 8'h7F);
		wr(8'h0A, 8'h00);
		busy = 1'b1; rd(8'h0A, 8'h80); busy = 1'b0;
		host_u.access(8'h20, 1'b1, 8'h11, 1'b0, q, drv); rd(8'h20, 8'hA5);
		host_u.access(8'h20, 1'b0, 8'h00, 1'b0, q, drv); chk1(drv, 1'b0);
		@(negedge clk) {supply, sram_in} = 2'b00;
		host_u.access(8'h20, 1'b1, 8'h22, 1'b1, q, drv); chk1(sram_out, 1'b1);
		host_u.access(8'h20, 1'b0, 8'h00, 1'b1, q, drv); chk1(drv, 1'b0);
		@(negedge clk) supply = 1'b1;
		repeat (2) @(negedge clk); chk1(sram_out, 1'b0);
		sram_in = 1'b1;
		rd(8'h20, 8'hA5); rd(8'h0C, 8'h00);
		wr(8'h0B, 8'h10);
		@(negedge clk) upd_evt = 1'b1;
		@(negedge clk) upd_evt = 1'b0;
		repeat (2) @(negedge clk); chk1(irq_oe_n, 1'b0);
		rd(8'h0C, 8'h90); chk1(irq_oe_n, 1'b1);
		wr(8'h0B, 8'h00);
		pulse_alarm; chk1(irq_oe_n, 1'b1);
		wr(8'h0B, 8'h20); chk1(irq_oe_n, 1'b0);
		rd(8'h0C, 8'hA0); chk1(irq_oe_n, 1'b1);
		rd(8'h0C, 8'h00);
		wr(8'h0B, 8'h7F);
		pulse_alarm; chk1(irq_oe_n, 1'b0);
		@(negedge clk) {reset_n, sram_in} = 2'b00;  // Held low by the system
		repeat (3) @(negedge clk); chkv({8'h00, ctrl_b}, 16'h0007);
		chk1(irq_oe_n, 1'b1); chk1(sram_out, 1'b1);
		chk1(irq_n, 1'b0);
		host_u.access(8'h20, 1'b0, 8'h00, 1'b1, q, drv); chk1(drv, 1'b0);
		@(negedge clk) reset_n = 1'b1;
		rd(8'h0C, 8'h00); rd(8'h20, 8'hA5);
		chk1(sram_out, 1'b0);
		sram_in = 1'b1;
		@(negedge clk) style = 1'b0;
		host_u.park;
		wr(8'h30, 8'h96); rd(8'h30, 8'h96);
		@(negedge clk) style = 1'b1;
		host_u.park;
		wr(8'h0B, 8'h08);
		for (int c = 0; c < 10; c++)
		begin
			wr(8'h0A, 8'(c));
			sqw_period(p);
			chkv(p, c == 0 ? 16'h0000 : 16'(TDIV << (c >= 3 ? c - 1 : c + 6)));
		end
		wr(8'h0B, 8'h00); sqw_period(p); chkv(p, 16'h0000);
		rd(8'h0C, 8'h40);
		wr(8'h0B, 8'h40);
		repeat (600) @(negedge clk); chk1(irq_oe_n, 1'b0);
		conclude;
	end
endmodule
